// [dv/fpb_props.sv]
/*
 checker for fpb_top: bus handshakes and the jtag grant pin.
 assumes a bind onto fpb_top, one clock domain.
*/
`timescale 1ns/1ps
module fpb_props
(
	input wire        I_CLK,
	input wire        I_RSTN,
	input wire        I_CE,
	input wire        I_AWVALID,
	input wire        O_AWREADY,
	input wire        I_WVALID,
	input wire        O_WREADY,
	input wire [1:0]  O_BRESP,
	input wire        O_BVALID,
	input wire        I_BREADY,
	input wire        I_ARVALID,
	input wire        O_ARREADY,
	input wire [31:0] O_RDATA,
	input wire        O_RVALID,
	input wire        I_RREADY,
	input wire        I_JTAG_REQ,
	input wire        O_JTAG_GRANT,
	input wire        O_IRQ
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);
	// handshakes only move while the clock enable is high
	AST_B_HOLD: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read data dropped early");
	AST_B_TURN: assert property (I_CE && I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
		|=> O_BVALID)
		else $error("write response late");
	AST_R_TURN: assert property (I_CE && I_ARVALID && O_ARREADY |=> O_RVALID)
		else $error("read response late");
	AST_AR_BLOCK: assert property (O_RVALID |-> !O_ARREADY)
		else $error("read taken while pending");
	AST_W_BLOCK: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
		else $error("write taken while pending");
	AST_B_ONE: assert property (I_CE && O_BVALID && I_BREADY |=> !O_BVALID)
		else $error("write response repeated");
	AST_GRANT_OFF: assert property ((I_CE && !I_JTAG_REQ) [*3] |-> !O_JTAG_GRANT)
		else $error("grant without request");
	cover property (O_BVALID && !I_BREADY);
	cover property (O_IRQ);
	cover property (O_JTAG_GRANT);
endmodule

// [dv/fpb_user.sv]
/*
 user-logic model: axi4-lite master, one write and one read at a time.
 assumes fpb_top on the same clock; slow delays the response readies.
*/
`timescale 1ns/1ps
module fpb_user
(
	input  wire        i_clk,
	output reg  [11:0] o_awaddr,
	output reg         o_awvalid,
	input  wire        i_awready,
	output reg  [31:0] o_wdata,
	output reg         o_wvalid,
	input  wire        i_wready,
	output reg         o_bready,
	input  wire        i_bvalid,
	output reg  [11:0] o_araddr,
	output reg         o_arvalid,
	input  wire        i_arready,
	output reg         o_rready,
	input  wire        i_rvalid,
	input  wire [31:0] i_rdata,
	input  wire [1:0]  i_rresp
);
	integer slow = 0;
	initial {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready, o_araddr, o_arvalid, o_rready} = 0;
	task wr(input [11:0] a, input [31:0] d);
		reg ta, tw;
		begin
			ta = 0;
			tw = 0;
			o_awaddr <= a;
			o_wdata <= d;
			o_awvalid <= 1'b1;
			o_wvalid <= 1'b1;
			while (!(ta && tw))
			begin
				@(posedge i_clk);
				if (i_awready) o_awvalid <= 1'b0;
				if (i_wready) o_wvalid <= 1'b0;
				ta = ta | i_awready;
				tw = tw | i_wready;
			end
			// released payload shows garbage, not the last value
			o_wdata <= ~d;
			repeat (slow) @(posedge i_clk);
			o_bready <= 1'b1;
			do @(posedge i_clk); while (!i_bvalid);
			o_bready <= 1'b0;
		end
	endtask
	task rd(input [11:0] a, output [31:0] d, output [1:0] r);
		begin
			o_araddr <= a;
			o_arvalid <= 1'b1;
			do @(posedge i_clk); while (!i_arready);
			o_arvalid <= 1'b0;
			o_araddr <= ~a;
			repeat (slow) @(posedge i_clk);
			o_rready <= 1'b1;
			do @(posedge i_clk); while (!i_rvalid);
			d = i_rdata;
			r = i_rresp;
			o_rready <= 1'b0;
		end
	endtask
endmodule

// [dv/tb_flash_page_buffer_access.sv]
/*
 testbench for fpb_top: random writes checked by read-back, protection,
 priority, interrupt and jtag lock. assumes fpb_user as bus master.
*/
`timescale 1ns/1ps
`include "fpb_defines.vh"
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_flash_page_buffer_access;
	reg         clk = 0, rstn = 0, jreq = 0, ce = 1;
	wire [11:0] awaddr, araddr;
	wire [31:0] wdata, rdata;
	wire [1:0]  bresp, rresp;
	wire        awvalid, awready, wvalid, wready, bvalid, bready;
	wire        arvalid, arready, rvalid, rready, grant, irq;
	integer     seed = 9820, err_count = 0, checks = 0, cyc = 0, i, k, n;
	reg  [7:0]  mem [0:15];
	reg  [31:0] d, v, cfg;
	reg  [1:0]  r, st, w;
	reg  [8:0]  a;
	fpb_top dut_u (.I_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_AWADDR(awaddr),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf),
		.I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
		.I_JTAG_REQ(jreq), .O_JTAG_GRANT(grant), .O_IRQ(irq));
	fpb_user usr (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
		.o_wdata(wdata), .o_wvalid(wvalid), .i_wready(wready), .o_bready(bready),
		.i_bvalid(bvalid), .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready),
		.o_rready(rready), .i_rvalid(rvalid), .i_rdata(rdata), .i_rresp(rresp));
	initial forever #5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			test_done;
		end
	end
	task test_done;
		begin
			if (err_count == 0 && checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	function [7:0] b(input [2:0] op);
		b = 8'h1 << op;
	endfunction
	function integer nbytes(input [1:0] wsel);
		nbytes = wsel[1] ? 4 : wsel[0] ? 2 : 1;
	endfunction
	function [31:0] exp_word(input [8:0] ad);
		exp_word = {mem[{ad[3:2], 2'h3}], mem[{ad[3:2], 2'h2}], mem[{ad[3:2], 2'h1}],
			mem[{ad[3:2], 2'h0}]};
	endfunction
	// ----------------------------------------
	// one operation, then poll until idle
	// ----------------------------------------
	task run(input [7:0] ops, input [1:0] wsel, input [8:0] ad, input [31:0] dat);
		reg [31:0] s;
		integer j;
		begin
			usr.wr(`FPB_REG_ADDR, {23'h0, ad});
			usr.wr(`FPB_REG_WDATA, dat);
			usr.wr(`FPB_REG_CTRL, cfg | {22'h0, wsel, ops});
			// busy may not show on the first cycles after the request
			repeat (3) @(posedge clk);
			s = 32'h4;
			for (j = 0; j < 60 && s[2] !== 1'b0; j++)
				usr.rd(`FPB_REG_STATUS, s, r);
			`CHK("op finished", 1'b0, s[2])
			st = s[1:0];
		end
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		cfg = 0;
		usr.wr(`FPB_REG_IRQ_MASK, 32'h1);
		usr.rd(12'h020, d, r);
		`CHK("unmapped resp", 2'h2, r)
		`CHK("unmapped data", 32'h0, d)
		run(b(`FPB_OP_ERASE), 2'h2, 9'h0, 32'h0);
		`CHK("erase status", `FPB_ST_OK, st)
		for (i = 0; i < 16; i++) mem[i] = 8'h0;
		for (i = 0; i < 14; i++)
		begin
			usr.slow = i % 3;
			w = (i < 4) ? i : $random(seed);
			a = $random(seed) & 9'hf;
			n = nbytes(w);
			v = $random(seed) & ((n == 4) ? 32'hffffffff : (32'h1 << (8 * n)) - 1);
			run(b(`FPB_OP_WRITE), w, a, v);
			for (k = 0; k < n; k++) mem[(a & ~(n - 1)) + k] = v[8 * k +: 8];
			run(b(`FPB_OP_READ), 2'h3, a, 32'h0);
			usr.rd(`FPB_REG_RDATA, d, r);
			`CHK("read back", exp_word(a), d)
		end
		cfg = 32'h1 << `FPB_CTRL_PLG_BIT;
		run(b(`FPB_OP_WRITE), 2'h0, 9'h0, 32'h5a);
		mem[0] = 8'h5a;
		run(b(`FPB_OP_WRITE), 2'h0, 9'h10, 32'h11);
		`CHK("page loss", `FPB_ST_PAGELOSS, st)
		cfg = 32'h1 << `FPB_CTRL_OWG_BIT;
		run(b(`FPB_OP_PROG), 2'h2, 9'h0, 32'h0);
		`CHK("guarded program", `FPB_ST_OK, st)
		cfg = 0;
		for (i = 3; i < 6; i++)
		begin
			run(b(i), 2'h0, 9'h0, 32'h77);
			`CHK("protected page", `FPB_ST_OVERWRITE, st)
		end
		run(b(`FPB_OP_UNPROT), 2'h2, 9'h0, 32'h0);
		run(b(`FPB_OP_PROG), 2'h2, 9'h0, 32'h0);
		run(b(`FPB_OP_WRITE), 2'h0, 9'h0, 32'h77);
		mem[0] = 8'h77;
		`CHK("unprotected write", `FPB_ST_OK, st)
		// read beats write, then write beats erase: both show in the read-back
		for (i = 0; i < 2; i++)
		begin
			run((b(`FPB_OP_READ) | b(`FPB_OP_WRITE)) << i, 2'h2, 9'h0, 32'ha5a5a5a5);
			if (i == 1)
				for (k = 0; k < 4; k++) mem[k] = 8'ha5;
			run(b(`FPB_OP_READ), 2'h3, 9'h0, 32'h0);
			usr.rd(`FPB_REG_RDATA, d, r);
			`CHK("priority read", exp_word(9'h0), d)
		end
		// dirty guarded page: each invalidating op must lift the page loss refusal
		cfg = 32'h1 << `FPB_CTRL_PLG_BIT;
		for (i = 0; i < 3; i++)
		begin
			run(b((i == 2) ? `FPB_OP_DISCARD : i), 2'h2, 9'h0, 32'h0);
			run(b(`FPB_OP_WRITE), 2'h0, (i % 2) ? 9'h0 : 9'h10, 32'h33);
			`CHK("write after drop", `FPB_ST_OK, st)
		end
		cfg = 0;
		`CHK("irq raised", 1'b1, irq)
		usr.wr(`FPB_REG_IRQ_MASK, 32'h0);
		@(posedge clk);
		`CHK("irq masked", 1'b0, irq)
		usr.wr(`FPB_REG_IRQ_MASK, 32'h1);
		usr.wr(`FPB_REG_IRQ_STAT, 32'h3);
		@(posedge clk);
		`CHK("irq cleared", 1'b0, irq)
		usr.wr(`FPB_REG_CTRL, 32'h1 << `FPB_CTRL_LOCK_BIT);
		jreq <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("jtag held", 1'b0, grant)
		usr.wr(`FPB_REG_CTRL, 32'h0);
		repeat (4) @(posedge clk);
		`CHK("jtag granted", 1'b1, grant)
		// clock enable low: the request synchroniser must not move
		ce <= 1'b0;
		jreq <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK("frozen grant", 1'b1, grant)
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("grant dropped", 1'b0, grant)
		test_done;
	end
endmodule
bind fpb_top fpb_props chk_u (.*);

// [hdl/fpb_core.v]
/*
 flash page buffer core: array, page buffer, block buffer, protection.
 assumes one request vector per cycle, sampled on the block clock.
*/
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fpb_defines.vh"
module fpb_core
(
	input  wire        i_clk,
	input  wire        i_rstn,
	input  wire        i_ce,
	input  wire [7:0]  i_req,
	input  wire [8:0]  i_addr,
	input  wire [1:0]  i_width,
	input  wire [31:0] i_wdata,
	input  wire        i_plg,
	input  wire        i_owg,
	output reg  [31:0] o_rdata,
	output reg  [1:0]  o_status,
	output reg         o_done,
	output reg         o_busy
);
	reg  [7:0]  arr_r [0:511];
	reg  [7:0]  page_r [0:15];
	reg  [7:0]  blk_r [0:3];
	reg  [31:0] prot_r;
	reg  [4:0]  page_idx_r;
	reg         page_valid_r;
	reg  [1:0]  blk_idx_r;
	reg         blk_valid_r;
	reg         dirty_r;
	reg  [3:0]  load_cnt_r;
	reg         loading_r;
	reg  [2:0]  op_r;
	reg  [8:0]  addr_r;
	reg  [1:0]  width_r;
	reg  [31:0] wdata_r;
	reg         owg_r;
	integer     k;
	// the priority pick owns its own loop index, so k keeps a single driver
	integer     m;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function [2:0] nbytes;
		input [1:0] w;
		begin
			nbytes = (w == 2'b00) ? 3'd1 : (w == 2'b01) ? 3'd2 : 3'd4;
		end
	endfunction

	function [8:0] align;
		input [8:0] a;
		input [1:0] w;
		begin
			align = (w == 2'b00) ? a : (w == 2'b01) ? {a[8:1], 1'b0} : {a[8:2], 2'b00};
		end
	endfunction

	// ---------------------------------------------------------------
	// priority pick among simultaneous requests
	// ---------------------------------------------------------------
	reg [2:0] pick;
	reg       any;
	always @*
	begin
		pick = 3'h0;
		any = 1'b0;
		for (m = 7; m >= 0; m = m - 1)
			if (i_req[m])
			begin
				pick = m[2:0];
				any = 1'b1;
			end
	end

	wire [8:0] al_a   = align(addr_r, width_r);
	wire [4:0] a_page = al_a[8:4];
	wire [1:0] a_blk  = al_a[3:2];
	wire       hit    = page_valid_r && (page_idx_r == a_page);

	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			prot_r <= 32'h0000_0000;
			page_idx_r <= 5'h00;
			page_valid_r <= 1'b0;
			blk_idx_r <= 2'h0;
			blk_valid_r <= 1'b0;
			dirty_r <= 1'b0;
			load_cnt_r <= 4'h0;
			loading_r <= 1'b0;
			op_r <= 3'h0;
			addr_r <= 9'h000;
			width_r <= 2'h0;
			wdata_r <= 32'h0000_0000;
			owg_r <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_status <= `FPB_ST_OK;
			o_done <= 1'b0;
			o_busy <= 1'b0;
		end
		else if (i_ce)
		begin
			o_done <= 1'b0;
			if (!o_busy)
			begin
				if (any)
				begin
					op_r <= pick;
					addr_r <= i_addr;
					width_r <= i_width;
					wdata_r <= i_wdata;
					owg_r <= i_owg;
					o_busy <= 1'b1;
				end
			end
			else if (loading_r)
			begin
				// page fill one byte per cycle keeps the array a simple memory
				page_r[load_cnt_r] <= arr_r[{a_page, load_cnt_r}];
				load_cnt_r <= load_cnt_r + 4'h1;
				if (load_cnt_r == `FPB_LOAD_LAST)
				begin
					loading_r <= 1'b0;
					page_idx_r <= a_page;
					page_valid_r <= 1'b1;
					blk_valid_r <= 1'b0;
				end
			end
			else
			begin
				o_busy <= 1'b0;
				o_done <= 1'b1;
				o_status <= `FPB_ST_OK;
				case (op_r)
				`FPB_OP_INIT, `FPB_OP_RESET:
				begin
					page_valid_r <= 1'b0;
					blk_valid_r <= 1'b0;
					dirty_r <= 1'b0;
				end
				`FPB_OP_READ:
				begin
					o_rdata <= 32'h0000_0000;
					for (k = 0; k < 4; k = k + 1)
						if (k < nbytes(width_r))
							o_rdata[8*k +: 8] <= hit ? page_r[al_a[3:0] + k[3:0]]
								: arr_r[al_a + k[8:0]];
				end
				`FPB_OP_WRITE:
				begin
					if (prot_r[a_page])
						o_status <= `FPB_ST_OVERWRITE;
					else if (page_valid_r && !hit && i_plg && dirty_r)
						o_status <= `FPB_ST_PAGELOSS;
					else if (!hit)
					begin
						o_busy <= 1'b1;
						o_done <= 1'b0;
						loading_r <= 1'b1;
						load_cnt_r <= 4'h0;
					end
					else if (!blk_valid_r || blk_idx_r != a_blk)
					begin
						for (k = 0; k < 4; k = k + 1)
							blk_r[k] <= page_r[{a_blk, k[1:0]}];
						blk_idx_r <= a_blk;
						blk_valid_r <= 1'b1;
						o_busy <= 1'b1;
						o_done <= 1'b0;
					end
					else
					begin
						for (k = 0; k < 4; k = k + 1)
							if (k < nbytes(width_r))
							begin
								blk_r[al_a[1:0] + k[1:0]] <= wdata_r[8*k +: 8];
								page_r[al_a[3:0] + k[3:0]] <= wdata_r[8*k +: 8];
							end
						dirty_r <= 1'b1;
					end
				end
				`FPB_OP_ERASE:
				begin
					if (prot_r[a_page])
						o_status <= `FPB_ST_OVERWRITE;
					else
					begin
						for (k = 0; k < 16; k = k + 1)
							arr_r[{a_page, k[3:0]}] <= 8'h00;
						if (hit)
							page_valid_r <= 1'b0;
					end
				end
				`FPB_OP_PROG:
				begin
					if (prot_r[a_page])
						o_status <= `FPB_ST_OVERWRITE;
					else
					begin
						if (hit)
							for (k = 0; k < 16; k = k + 1)
								arr_r[{a_page, k[3:0]}] <= page_r[k];
						prot_r[a_page] <= owg_r;
						dirty_r <= 1'b0;
					end
				end
				`FPB_OP_UNPROT:
					prot_r[a_page] <= 1'b0;
				default:
				begin
					page_valid_r <= 1'b0;
					blk_valid_r <= 1'b0;
					dirty_r <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule

// [hdl/fpb_defines.vh]
/*
 constants for the flash page buffer access block: register offsets,
 field positions, reset values, status codes and operation priorities.
 assumes inclusion by bare name from the design files under hdl/.
*/
`ifndef FPB_DEFINES_VH
`define FPB_DEFINES_VH

`define FPB_ADDR_W        9
`define FPB_PAGE_BYTES    16
`define FPB_BLOCK_BYTES   4
`define FPB_PAGES         32
`define FPB_LOAD_LAST     4'hf

`define FPB_REG_CTRL      12'h000
`define FPB_REG_ADDR      12'h004
`define FPB_REG_WDATA     12'h008
`define FPB_REG_RDATA     12'h00c
`define FPB_REG_STATUS    12'h010
`define FPB_REG_IRQ_STAT  12'h014
`define FPB_REG_IRQ_MASK  12'h018

`define FPB_CTRL_OP_LSB   0
`define FPB_CTRL_WID_LSB  8
`define FPB_CTRL_PLG_BIT  10
`define FPB_CTRL_OWG_BIT  11
`define FPB_CTRL_LOCK_BIT 12

`define FPB_OP_INIT       3'h0
`define FPB_OP_RESET      3'h1
`define FPB_OP_READ       3'h2
`define FPB_OP_WRITE      3'h3
`define FPB_OP_ERASE      3'h4
`define FPB_OP_PROG       3'h5
`define FPB_OP_UNPROT     3'h6
`define FPB_OP_DISCARD    3'h7

`define FPB_ST_OK         2'h0
`define FPB_ST_OVERWRITE  2'h1
`define FPB_ST_PAGELOSS   2'h3

`define FPB_IRQ_DONE_BIT  0
`define FPB_IRQ_ERR_BIT   1
`define FPB_CTRL_RST      32'h0000_0000

`endif

// [hdl/fpb_top.v]
/*
 flash page buffer access top: axi4-lite slave, jtag pin synchroniser,
 jtag lock gate and interrupt logic around fpb_core.
 assumes a single 100 mhz clock and an axi master on that clock.
*/
`timescale 1ns/1ps
`include "fpb_defines.vh"
module fpb_top
(
	input  wire        I_CLK,
	input  wire        I_RSTN,
	input  wire        I_CE,
	input  wire [11:0] I_AWADDR,
	input  wire        I_AWVALID,
	output wire        O_AWREADY,
	input  wire [31:0] I_WDATA,
	input  wire [3:0]  I_WSTRB,
	input  wire        I_WVALID,
	output wire        O_WREADY,
	output reg  [1:0]  O_BRESP,
	output reg         O_BVALID,
	input  wire        I_BREADY,
	input  wire [11:0] I_ARADDR,
	input  wire        I_ARVALID,
	output wire        O_ARREADY,
	output reg  [31:0] O_RDATA,
	output reg  [1:0]  O_RRESP,
	output reg         O_RVALID,
	input  wire        I_RREADY,
	input  wire        I_JTAG_REQ,
	output wire        O_JTAG_GRANT,
	output wire        O_IRQ
);
	reg  [31:0] ctrl_r;
	reg  [8:0]  addr_r;
	reg  [31:0] wdata_r;
	reg  [1:0]  irq_stat_r;
	reg  [1:0]  irq_mask_r;
	reg  [7:0]  req_r;
	reg  [11:0] awaddr_r;
	reg         aw_held_r;
	reg  [31:0] wbuf_r;
	reg         w_held_r;
	reg  [1:0]  jtag_sync_r;
	wire [31:0] core_rdata;
	wire [1:0]  core_status;
	wire        core_done;
	wire        core_busy;

	// ---------------------------------------------------------------
	// jtag request sync and lock gate
	// ---------------------------------------------------------------
	always @(posedge I_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			jtag_sync_r <= 2'b00;
		else if (I_CE)
			jtag_sync_r <= {jtag_sync_r[0], I_JTAG_REQ};
	end
	// held off, not dropped: grant rises once the lock clears
	assign O_JTAG_GRANT = jtag_sync_r[1] & ~ctrl_r[`FPB_CTRL_LOCK_BIT];

	// ---------------------------------------------------------------
	// axi4-lite write path
	// ---------------------------------------------------------------
	assign O_AWREADY = !aw_held_r && !O_BVALID;
	assign O_WREADY  = !w_held_r && !O_BVALID;
	assign O_ARREADY = !O_RVALID;
	wire        aw_ok  = aw_held_r || (I_AWVALID && O_AWREADY);
	wire        w_ok   = w_held_r || (I_WVALID && O_WREADY);
	wire [11:0] wa     = aw_held_r ? awaddr_r : I_AWADDR;
	wire [31:0] wv     = w_held_r ? wbuf_r : I_WDATA;
	wire        wr_go  = aw_ok && w_ok && !O_BVALID;
	wire [1:0]  ev     = {core_done && core_status != `FPB_ST_OK, core_done};

	always @(posedge I_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			ctrl_r <= `FPB_CTRL_RST;
			addr_r <= 9'h000;
			wdata_r <= 32'h0000_0000;
			irq_stat_r <= 2'b00;
			irq_mask_r <= 2'b00;
			req_r <= 8'h00;
			awaddr_r <= 12'h000;
			aw_held_r <= 1'b0;
			wbuf_r <= 32'h0000_0000;
			w_held_r <= 1'b0;
			O_BVALID <= 1'b0;
			O_BRESP <= 2'b00;
		end
		else if (I_CE)
		begin
			req_r <= 8'h00;
			if (I_AWVALID && O_AWREADY && !wr_go)
			begin
				awaddr_r <= I_AWADDR;
				aw_held_r <= 1'b1;
			end
			if (I_WVALID && O_WREADY && !wr_go)
			begin
				wbuf_r <= I_WDATA;
				w_held_r <= 1'b1;
			end
			if (O_BVALID && I_BREADY)
				O_BVALID <= 1'b0;
			irq_stat_r <= irq_stat_r | ev;
			if (wr_go)
			begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				O_BVALID <= 1'b1;
				O_BRESP <= 2'b00;
				case (wa)
				`FPB_REG_CTRL:
				begin
					ctrl_r <= wv & 32'h0000_1f00;
					req_r <= wv[7:0];
				end
				`FPB_REG_ADDR:
					addr_r <= wv[8:0];
				`FPB_REG_WDATA:
					wdata_r <= wv;
				`FPB_REG_IRQ_STAT:
					irq_stat_r <= (irq_stat_r & ~wv[1:0]) | ev;
				`FPB_REG_IRQ_MASK:
					irq_mask_r <= wv[1:0];
				`FPB_REG_RDATA, `FPB_REG_STATUS:
					O_BRESP <= 2'b00;
				default:
					O_BRESP <= 2'b10;
				endcase
			end
		end
	end
	assign O_IRQ = |(irq_stat_r & irq_mask_r);

	// ---------------------------------------------------------------
	// axi4-lite read path
	// ---------------------------------------------------------------
	always @(posedge I_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= 2'b00;
		end
		else if (I_CE)
		begin
			if (O_RVALID && I_RREADY)
				O_RVALID <= 1'b0;
			if (I_ARVALID && O_ARREADY)
			begin
				O_RVALID <= 1'b1;
				O_RRESP <= 2'b00;
				case (I_ARADDR)
				`FPB_REG_CTRL:     O_RDATA <= ctrl_r;
				`FPB_REG_ADDR:     O_RDATA <= {23'h0, addr_r};
				`FPB_REG_WDATA:    O_RDATA <= wdata_r;
				`FPB_REG_RDATA:    O_RDATA <= core_rdata;
				`FPB_REG_STATUS:   O_RDATA <= {29'h0, core_busy, core_status};
				`FPB_REG_IRQ_STAT: O_RDATA <= {30'h0, irq_stat_r};
				`FPB_REG_IRQ_MASK: O_RDATA <= {30'h0, irq_mask_r};
				default:
				begin
					O_RDATA <= 32'h0000_0000;
					O_RRESP <= 2'b10;
				end
				endcase
			end
		end
	end

	fpb_core u_core
	(
		.i_clk    (I_CLK),
		.i_rstn   (I_RSTN),
		.i_ce     (I_CE),
		.i_req    (req_r),
		.i_addr   (addr_r),
		.i_width  (ctrl_r[`FPB_CTRL_WID_LSB +: 2]),
		.i_wdata  (wdata_r),
		.i_plg    (ctrl_r[`FPB_CTRL_PLG_BIT]),
		.i_owg    (ctrl_r[`FPB_CTRL_OWG_BIT]),
		.o_rdata  (core_rdata),
		.o_status (core_status),
		.o_done   (core_done),
		.o_busy   (core_busy)
	);
endmodule
